// >>> hw/pfc_pkg.sv
/*
 * Shared constants, register indices and carrier types of the pause
 * and priority flow-control block.
 * Assumes a single clock domain and an APB register master.
 */
package pfc_pkg;
    // ********************************
    // Sizes
    // ********************************
    localparam int NCLS = 9;
    localparam int NPRI = 8;
    localparam int GLB = 8;
    localparam int QW = 16;
    localparam int AW = 48;
    localparam int DW = 32;
    localparam int PAW = 8;
    localparam int IDX_LSB = 2;
    localparam int IW = PAW - IDX_LSB;
    localparam int CW = 4;
    localparam int NGRP = 4;
    // ********************************
    // Register indices (byte address is index times four)
    // ********************************
    localparam int R_TX_EN = 0;
    localparam int R_RX_CTL = 1;
    localparam int R_RX_CHK = 2;
    localparam int R_TX_GTYPE = 3;
    localparam int R_TX_PTYPE = 4;
    localparam int R_TX_GDA = 5;
    localparam int R_TX_GSA = 7;
    localparam int R_TX_PDA = 9;
    localparam int R_TX_PSA = 11;
    localparam int R_RX_UDA = 13;
    localparam int R_RX_MDA = 15;
    localparam int R_RX_SA = 17;
    localparam int R_RX_GCP_ET = 19;
    localparam int R_RX_GCP_OP = 20;
    localparam int R_RX_PCP_ET = 21;
    localparam int R_RX_PCP_OP = 22;
    localparam int R_RX_GPP = 23;
    localparam int R_RX_PPP = 24;
    localparam int R_TX_QT = 25;
    localparam int NCFG = 34;
    localparam int R_STATUS = 34;
    // ********************************
    // Field positions and reset values
    // ********************************
    localparam int F_ACK = 9;
    localparam int F_FWD = 10;
    localparam int F_LO16 = 0;
    localparam int F_HI16 = 16;
    localparam int HI_W = 16;
    localparam int CHK_STRIDE = 8;
    localparam int CHK_W = 6;
    localparam int G_GCP = 0;
    localparam int G_PCP = 1;
    localparam int G_GPP = 2;
    localparam int G_PPP = 3;
    localparam int STAT_PEND = 16;
    localparam logic [DW-1:0] CFG_RST = 32'h0000_0000;
    // ********************************
    // Carrier types
    // ********************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PAW-1:0] paddr;
        logic [DW-1:0] pwdata;
    } pfc_apb_req_type;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DW-1:0] prdata;
    } pfc_apb_rsp_type;
    typedef struct packed {
        logic [AW-1:0] da;
        logic [AW-1:0] sa;
        logic [QW-1:0] etype;
        logic [QW-1:0] opcode;
    } pfc_hdr_type;
    typedef struct packed {
        logic valid;
        logic glb;
        pfc_hdr_type hdr;
        logic [NPRI-1:0] cev;
        logic [NPRI-1:0][QW-1:0] quanta;
    } pfc_frame_type;
    typedef struct packed {
        logic en;
        logic mc;
        logic uc;
        logic sa;
        logic et;
        logic op;
    } pfc_chk_type;
    typedef enum logic {PFC_IDLE, PFC_SEND} pfc_tx_st_type;
endpackage

// >>> hw/pfc_hdr_check.sv
/*
 * One group of receive header checks (address, ethertype, opcode).
 * Assumes the header is stable while its valid strobe is high.
 */
`timescale 1ns/1ps
module pfc_hdr_check (
    // Check controls and header
    input pfc_pkg::pfc_chk_type chk,
    input pfc_pkg::pfc_hdr_type hdr,
    // References
    input logic [pfc_pkg::AW-1:0] uda,
    input logic [pfc_pkg::AW-1:0] mda,
    input logic [pfc_pkg::AW-1:0] sar,
    input logic [pfc_pkg::QW-1:0] etr,
    input logic [pfc_pkg::QW-1:0] omin,
    input logic [pfc_pkg::QW-1:0] omax,
    // Result
    output logic pass
);
    import pfc_pkg::*;
    logic da_ok;
    always_comb begin
        da_ok = (!chk.mc && !chk.uc) || (chk.mc && hdr.da == mda)
            || (chk.uc && hdr.da == uda);
        pass = chk.en && da_ok && (!chk.sa || hdr.sa == sar)
            && (!chk.et || hdr.etype == etr)
            && (!chk.op || (hdr.opcode >= omin && hdr.opcode <= omax));
    end
endmodule // pfc_hdr_check

// >>> hw/pfc_cls_timer.sv
/*
 * Per-class pending flag and refresh timer for pause transmission.
 * Assumes request, resend and sent strobes on the same clock.
 */
`timescale 1ns/1ps
module pfc_cls_timer (
    // Clock and reset
    input logic ref_clk,
    input logic srst,
    // Controls
    input logic req,
    input logic en,
    input logic resend,
    input logic sent,
    input logic [pfc_pkg::QW-1:0] refresh,
    // State
    output logic pend
);
    import pfc_pkg::*;
    typedef struct packed {
        logic req_p;
        logic pend;
        logic armed;
        logic [QW-1:0] tmr;
    } pfc_tmr_state_type;
    localparam pfc_tmr_state_type TMR_RST = '0;
    pfc_tmr_state_type q;
    pfc_tmr_state_type d;
    logic expire;
    logic set;
    always_comb begin
        d = q;
        d.req_p = req;
        expire = req && q.armed && q.tmr == '0 && refresh != '0;
        set = (req && !q.req_p) || expire || (resend && req);
        d.pend = en && (set || (q.pend && !sent));
        if (sent || resend) begin
            d.tmr = refresh;
            d.armed = sent || q.armed;
        end else if (!req || expire) begin
            d.armed = 1'b0;
        end else if (q.armed && q.tmr != '0) begin
            d.tmr = q.tmr - 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= TMR_RST;
        end else begin
            q <= d;
        end
    end
    assign pend = q.pend;
    property p_off;
        @(posedge ref_clk) disable iff (srst) !en |=> !pend;
    endproperty
    a_off: assert property (p_off)
        else $error("pause pending while class disabled");
    property p_resend;
        @(posedge ref_clk) disable iff (srst)
            resend && req && en |=> pend;
    endproperty
    a_resend: assert property (p_resend)
        else $error("resend did not make frame pending");
endmodule // pfc_cls_timer

// >>> hw/pfc_top.sv
/*
 * Pause and priority flow control: APB registers, pause frame
 * scheduling on transmit, control and pause frame checks on receive.
 * Assumes the MAC, the user logic and APB share ref_clk.
 */
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module pfc_top (
    // Clock and reset
    input logic ref_clk,
    input logic srst,
    // APB slave
    input pfc_pkg::pfc_apb_req_type apb_req,
    output pfc_pkg::pfc_apb_rsp_type apb_rsp,
    // Transmit requests and frame
    input logic [pfc_pkg::NCLS-1:0] tx_pause_req,
    input logic tx_resend_pause,
    output pfc_pkg::pfc_frame_type tx_frm,
    input logic tx_frm_done,
    output logic [pfc_pkg::NCLS-1:0] tx_pause_sent,
    // Receive header and user outputs
    input pfc_pkg::pfc_frame_type rx_hdr,
    input logic [pfc_pkg::NCLS-1:0] rx_pause_ack,
    output logic [pfc_pkg::NCLS-1:0] rx_pause_valid,
    output logic [pfc_pkg::NCLS-1:0][pfc_pkg::QW-1:0] rx_pause_quanta,
    output logic [pfc_pkg::NCLS-1:0] rx_pause_req,
    output logic rx_ctl_fwd,
    output logic rx_ctl_drop
);
    import pfc_pkg::*;
    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [NCFG-1:0][DW-1:0] cfg;
        pfc_apb_rsp_type rsp;
        pfc_tx_st_type st;
        logic [CW-1:0] cls;
        pfc_frame_type frm;
        logic [NCLS-1:0] sent;
        logic [NCLS-1:0] rq_int;
        logic [NCLS-1:0] rx_vld;
        logic [NCLS-1:0][QW-1:0] rx_qt;
        logic [NCLS-1:0] rx_req;
        logic fwd;
        logic drop;
    } pfc_top_state_type;
    localparam pfc_top_state_type TOP_RST = '0;
    pfc_top_state_type q;
    pfc_top_state_type d;
    logic [NCLS-1:0] pend;
    logic [NCLS-1:0] sent_now;
    logic [NCLS-1:0] acc_now;
    logic [NCLS-1:0] rxen;
    logic [NGRP-1:0] pass;
    logic [NGRP-1:0][QW-1:0] et_ref;
    logic [NGRP-1:0][QW-1:0] op_min;
    logic [NGRP-1:0][QW-1:0] op_max;
    logic [IW-1:0] idx;
    logic [CW-1:0] pick;
    logic [DW-1:0] stat;
    logic acc;
    logic glb;
    logic ack_on;
    logic fwd_en;
    logic ctl;
    // ********************************
    // Helpers
    // ********************************
    function automatic logic [AW-1:0] addr48(input logic [DW-1:0] lo,
            input logic [DW-1:0] hi);
        return {hi[HI_W-1:0], lo};
    endfunction
    function automatic logic is_cfg(input logic [PAW-1:0] a);
        return a[IDX_LSB-1:0] == '0 && a[PAW-1:IDX_LSB] < IW'(NCFG);
    endfunction
    function automatic logic is_stat(input logic [PAW-1:0] a);
        return a[IDX_LSB-1:0] == '0 && a[PAW-1:IDX_LSB] == IW'(R_STATUS);
    endfunction
    function automatic logic [QW-1:0] lo16(input logic [DW-1:0] w);
        return w[F_LO16 +: QW];
    endfunction
    function automatic logic [QW-1:0] hi16(input logic [DW-1:0] w);
        return w[F_HI16 +: QW];
    endfunction
    // ********************************
    // Per-class transmit timers
    // ********************************
    for (genvar g = 0; g < NCLS; g++) begin : g_tmr
        pfc_cls_timer u_tmr (
            .ref_clk(ref_clk),
            .srst(srst),
            .req(tx_pause_req[g]),
            .en(q.cfg[R_TX_EN][g]),
            .resend(tx_resend_pause),
            .sent(sent_now[g]),
            .refresh(hi16(q.cfg[R_TX_QT+g])),
            .pend(pend[g])
        );
    end
    // ********************************
    // Receive header checks
    // ********************************
    always_comb begin
        et_ref[G_GCP] = lo16(q.cfg[R_RX_GCP_ET]);
        op_min[G_GCP] = lo16(q.cfg[R_RX_GCP_OP]);
        op_max[G_GCP] = hi16(q.cfg[R_RX_GCP_OP]);
        et_ref[G_PCP] = lo16(q.cfg[R_RX_PCP_ET]);
        op_min[G_PCP] = lo16(q.cfg[R_RX_PCP_OP]);
        op_max[G_PCP] = hi16(q.cfg[R_RX_PCP_OP]);
        et_ref[G_GPP] = lo16(q.cfg[R_RX_GPP]);
        op_min[G_GPP] = hi16(q.cfg[R_RX_GPP]);
        op_max[G_GPP] = hi16(q.cfg[R_RX_GPP]);
        et_ref[G_PPP] = lo16(q.cfg[R_RX_PPP]);
        op_min[G_PPP] = hi16(q.cfg[R_RX_PPP]);
        op_max[G_PPP] = hi16(q.cfg[R_RX_PPP]);
    end
    for (genvar g = 0; g < NGRP; g++) begin : g_chk
        pfc_hdr_check u_chk (
            .chk(pfc_chk_type'(q.cfg[R_RX_CHK][g*CHK_STRIDE +: CHK_W])),
            .hdr(rx_hdr.hdr),
            .uda(addr48(q.cfg[R_RX_UDA], q.cfg[R_RX_UDA+1])),
            .mda(addr48(q.cfg[R_RX_MDA], q.cfg[R_RX_MDA+1])),
            .sar(addr48(q.cfg[R_RX_SA], q.cfg[R_RX_SA+1])),
            .etr(et_ref[g]),
            .omin(op_min[g]),
            .omax(op_max[g]),
            .pass(pass[g])
        );
    end
    // ********************************
    // Next state
    // ********************************
    always_comb begin
        d = q;
        idx = apb_req.paddr[PAW-1:IDX_LSB];
        acc = apb_req.psel && apb_req.penable;
        stat = CFG_RST;
        stat[NCLS-1:0] = q.rq_int;
        stat[STAT_PEND +: NCLS] = pend;
        d.rsp.pready = 1'b0;
        d.rsp.pslverr = 1'b0;
        // APB: one wait state, write lands on the ready edge
        if (acc && !q.rsp.pready) begin
            d.rsp.pready = 1'b1;
            d.rsp.prdata = CFG_RST;
            if (is_cfg(apb_req.paddr)) begin
                d.rsp.prdata = q.cfg[idx];
            end else if (is_stat(apb_req.paddr) && !apb_req.pwrite) begin
                d.rsp.prdata = stat;
            end else begin
                d.rsp.pslverr = 1'b1;
            end
        end
        if (acc && q.rsp.pready && apb_req.pwrite
                && is_cfg(apb_req.paddr)) begin
            d.cfg[idx] = apb_req.pwdata;
        end
        // Transmit scheduling, global class has the top priority
        pick = '0;
        for (int i = 0; i < NCLS; i++) begin
            if (pend[i]) begin
                pick = CW'(i);
            end
        end
        glb = pick == CW'(GLB);
        sent_now = '0;
        case (q.st)
            PFC_IDLE: begin
                if (|pend) begin
                    d.st = PFC_SEND;
                    d.cls = pick;
                    d.frm.valid = 1'b1;
                    d.frm.glb = glb;
                    d.frm.quanta = '0;
                    d.frm.cev = '0;
                    if (glb) begin
                        d.frm.hdr.da = addr48(q.cfg[R_TX_GDA],
                            q.cfg[R_TX_GDA+1]);
                        d.frm.hdr.sa = addr48(q.cfg[R_TX_GSA],
                            q.cfg[R_TX_GSA+1]);
                        d.frm.hdr.etype = lo16(q.cfg[R_TX_GTYPE]);
                        d.frm.hdr.opcode = hi16(q.cfg[R_TX_GTYPE]);
                        d.frm.quanta[0] = lo16(q.cfg[R_TX_QT+GLB]);
                    end else begin
                        d.frm.hdr.da = addr48(q.cfg[R_TX_PDA],
                            q.cfg[R_TX_PDA+1]);
                        d.frm.hdr.sa = addr48(q.cfg[R_TX_PSA],
                            q.cfg[R_TX_PSA+1]);
                        d.frm.hdr.etype = lo16(q.cfg[R_TX_PTYPE]);
                        d.frm.hdr.opcode = hi16(q.cfg[R_TX_PTYPE]);
                        d.frm.cev[pick[CW-2:0]] = 1'b1;
                        d.frm.quanta[pick[CW-2:0]] =
                            lo16(q.cfg[R_TX_QT+int'(pick)]);
                    end
                end
            end
            PFC_SEND: begin
                if (tx_frm_done) begin
                    d.st = PFC_IDLE;
                    d.frm.valid = 1'b0;
                    sent_now[q.cls] = 1'b1;
                end
            end
            default: begin
                d.st = PFC_IDLE;
            end
        endcase
        d.sent = sent_now;
        // Receive classification
        ack_on = q.cfg[R_RX_CTL][F_ACK];
        fwd_en = q.cfg[R_RX_CTL][F_FWD];
        rxen = q.cfg[R_RX_CTL][NCLS-1:0];
        ctl = rx_hdr.valid && (|pass);
        acc_now[GLB] = rx_hdr.valid && pass[G_GPP];
        for (int i = 0; i < NPRI; i++) begin
            acc_now[i] = rx_hdr.valid && pass[G_PPP] && rx_hdr.cev[i];
        end
        // Set wins over the acknowledge clear
        for (int i = 0; i < NCLS; i++) begin
            d.rq_int[i] = acc_now[i]
                || (q.rq_int[i] && ack_on && !rx_pause_ack[i]);
        end
        d.rx_vld = acc_now & rxen;
        if (acc_now[GLB] && rxen[GLB]) begin
            d.rx_qt[GLB] = rx_hdr.quanta[0];
        end
        for (int i = 0; i < NPRI; i++) begin
            if (acc_now[i] && rxen[i]) begin
                d.rx_qt[i] = rx_hdr.quanta[i];
            end
        end
        d.rx_req = d.rq_int & rxen;
        d.fwd = ctl && fwd_en;
        d.drop = ctl && !fwd_en;
    end
    // ********************************
    // Registers and outputs
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= TOP_RST;
        end else begin
            q <= d;
        end
    end
    assign apb_rsp = q.rsp;
    assign tx_frm = q.frm;
    assign tx_pause_sent = q.sent;
    assign rx_pause_valid = q.rx_vld;
    assign rx_pause_quanta = q.rx_qt;
    assign rx_pause_req = q.rx_req;
    assign rx_ctl_fwd = q.fwd;
    assign rx_ctl_drop = q.drop;
    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    property p_glb_first;
        q.st == PFC_IDLE && pend[GLB] |=> tx_frm.valid && tx_frm.glb;
    endproperty
    a_glb_first: assert property (p_glb_first)
        else $error("global pause not sent first");
    property p_sent;
        q.st == PFC_SEND && tx_frm_done |=> $onehot(tx_pause_sent)
            && tx_pause_sent[GLB] == ($past(q.cls) == CW'(GLB));
    endproperty
    a_sent: assert property (p_sent)
        else $error("sent pulse wrong");
    property p_gda;
        $rose(tx_frm.valid) && tx_frm.glb |-> tx_frm.hdr.da ==
            {$past(q.cfg[R_TX_GDA+1][HI_W-1:0]), $past(q.cfg[R_TX_GDA])};
    endproperty
    a_gda: assert property (p_gda)
        else $error("global destination wrong");
    property p_pet;
        $rose(tx_frm.valid) && !tx_frm.glb |->
            tx_frm.hdr.etype == $past(q.cfg[R_TX_PTYPE][F_LO16 +: QW]);
    endproperty
    a_pet: assert property (p_pet)
        else $error("priority ethertype wrong");
    property p_gqt;
        $rose(tx_frm.valid) && tx_frm.glb |->
            tx_frm.quanta[0] == $past(q.cfg[R_TX_QT+GLB][F_LO16 +: QW]);
    endproperty
    a_gqt: assert property (p_gqt)
        else $error("global quanta wrong");
    property p_rx_glb;
        rx_hdr.valid && pass[G_GPP] |=>
            rx_pause_valid[GLB] == $past(rxen[GLB]);
    endproperty
    a_rx_glb: assert property (p_rx_glb)
        else $error("global receive valid wrong");
    property p_rx_qt;
        rx_hdr.valid && pass[G_GPP] && rxen[GLB] |=>
            rx_pause_quanta[GLB] == $past(rx_hdr.quanta[0]);
    endproperty
    a_rx_qt: assert property (p_rx_qt)
        else $error("global receive quanta wrong");
    property p_hold;
        q.rq_int[GLB] && ack_on && !rx_pause_ack[GLB] |=> q.rq_int[GLB];
    endproperty
    a_hold: assert property (p_hold)
        else $error("receive request dropped before ack");
    property p_noack;
        !ack_on && !acc_now[GLB] |=> !q.rq_int[GLB];
    endproperty
    a_noack: assert property (p_noack)
        else $error("receive request waited with ack off");
    property p_drop;
        ctl && !fwd_en |=> rx_ctl_drop && !rx_ctl_fwd;
    endproperty
    a_drop: assert property (p_drop)
        else $error("control frame not dropped");
endmodule // pfc_top

// >>> test/pfc_mac_model.sv
/*
 * MAC side stand-in: takes each pause frame after a set delay.
 * Assumes the frame stays valid until its done pulse is seen.
 */
`timescale 1ns/1ps
module pfc_mac_model (
    // Clock and reset
    input logic ref_clk,
    input logic srst,
    // Frame handshake
    input logic frm_valid,
    input logic [3:0] delay,
    output logic frm_done
);
    int cnt_q;
    // ********
    // Done pulse delay+1 cycles after the frame turns valid
    // ********
    always_ff @(posedge ref_clk) begin
        if (srst || !frm_valid || frm_done) begin
            cnt_q <= 0;
            frm_done <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1;
            frm_done <= (cnt_q == int'(delay));
        end
    end
endmodule // pfc_mac_model

// >>> test/tb_pfc_top.sv
/*
 * Self-checking bench: APB set-up, pause send order and content,
 * receive checks, acks and masks.
 * Assumes the MAC stand-in model and the design package.
 */
`timescale 1ns/1ps
module tb_pfc_top;
    import pfc_pkg::*;
    localparam logic [15:0] GOP = 16'h0001;
    localparam logic [15:0] POP = 16'h0101;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    pfc_apb_req_type apb_req = '0;
    pfc_apb_rsp_type apb_rsp;
    logic [NCLS-1:0] tx_req = '0, tx_sent, rx_ack = '0, rx_valid, rx_req;
    logic tx_resend = 1'b0, tx_done, rx_fwd, rx_drop, err;
    logic [3:0] dly = 4'h2;
    pfc_frame_type tx_frm, rx_hdr = '0;
    logic [NCLS-1:0][QW-1:0] rx_q;
    logic [QW-1:0] txq [NCLS];
    logic [AW-1:0] gda, pda;
    logic [31:0] rd, gty, pty;
    int failures = 0, compares = 0, cyc = 0, sent_cls = -1, cls_q[$];

    always #12.5 ref_clk = ~ref_clk;

    pfc_top pfc_top_i (.ref_clk(ref_clk), .srst(srst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .tx_pause_req(tx_req),
        .tx_resend_pause(tx_resend), .tx_frm(tx_frm), .tx_frm_done(tx_done),
        .tx_pause_sent(tx_sent), .rx_hdr(rx_hdr), .rx_pause_ack(rx_ack),
        .rx_pause_valid(rx_valid), .rx_pause_quanta(rx_q),
        .rx_pause_req(rx_req), .rx_ctl_fwd(rx_fwd), .rx_ctl_drop(rx_drop));
    pfc_mac_model pfc_mac_model_i (.ref_clk(ref_clk), .srst(srst),
        .frm_valid(tx_frm.valid), .delay(dly), .frm_done(tx_done));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input int idx, input logic [31:0] d);
        @(posedge ref_clk);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= w;
        apb_req.paddr <= 8'(idx * 4);
        apb_req.pwdata <= d;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic chk_frame(input int c);
        logic g;
        g = (c == GLB);
        chk(tx_frm.glb, g);
        chk(tx_frm.hdr.da, g ? gda : pda);
        chk({tx_frm.hdr.opcode, tx_frm.hdr.etype}, g ? gty : pty);
        chk(tx_frm.cev, g ? 64'h0 : 64'h1 << c);
        chk(tx_frm.quanta[g ? 0 : c], txq[c]);
    endtask

    task automatic wait_q();
        int n;
        n = 0;
        while ((cls_q.size() != 0 || sent_cls >= 0) && n < 500) begin
            @(posedge ref_clk);
            n++;
        end
        chk(cls_q.size(), 0);
    endtask

    task automatic rx_send(input logic [15:0] op, input logic [7:0] cev,
            input logic [8:0] en, input logic fwd);
        logic [8:0] ev;
        logic [15:0] q;
        logic ctl;
        q = 16'($urandom());
        ev = (op == GOP) ? 9'h100 : (op == POP) ? {1'b0, cev} : 9'h000;
        ctl = (ev != 0) || (op >= 16'h0200 && op <= 16'h0300);
        @(posedge ref_clk);
        rx_hdr.valid <= 1'b1;
        rx_hdr.glb <= (op == GOP);
        rx_hdr.hdr.opcode <= op;
        rx_hdr.cev <= cev;
        for (int i = 0; i < NPRI; i++) begin
            rx_hdr.quanta[i] <= q + 16'(i);
        end
        @(posedge ref_clk);
        rx_hdr.valid <= 1'b0;
        @(posedge ref_clk);
        chk(rx_valid, ev & en);
        chk(rx_fwd, ctl && fwd);
        chk(rx_drop, ctl && !fwd);
        for (int i = 0; i < NCLS; i++) begin
            if (ev[i] && en[i]) begin
                chk(rx_q[i], (i == GLB) ? q : q + 16'(i));
            end
        end
    endtask

    // ********
    // Frame monitor and timeout
    // ********
    always @(posedge ref_clk) begin
        if (srst === 1'b0) begin
            chk(tx_sent, (sent_cls < 0) ? 64'h0 : 64'h1 << sent_cls);
            sent_cls = -1;
            if (tx_frm.valid === 1'b1 && tx_done === 1'b1) begin
                if (cls_q.size() == 0) begin
                    chk(tx_frm.valid, 1'b0);
                end else begin
                    sent_cls = cls_q.pop_front();
                    chk_frame(sent_cls);
                end
            end
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            finish_test();
        end
    end

    // ********
    // Main sequence
    // ********
    initial begin
        void'($urandom(11));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        apb(1'b0, R_TX_EN, 32'h0);
        chk(rd, CFG_RST);
        apb(1'b0, 40, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, R_STATUS, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b1, R_TX_EN, 32'h0000_01FF);
        apb(1'b0, R_TX_EN, 32'h0);
        chk(rd, 32'h0000_01FF);
        $display("test registers done");
        gda = 48'({$urandom(), $urandom()});
        pda = 48'({$urandom(), $urandom()});
        gty = $urandom();
        pty = $urandom();
        apb(1'b1, R_TX_GTYPE, gty);
        apb(1'b1, R_TX_PTYPE, pty);
        apb(1'b1, R_TX_GDA, gda[31:0]);
        apb(1'b1, R_TX_GDA + 1, 32'(gda[47:32]));
        apb(1'b1, R_TX_PDA, pda[31:0]);
        apb(1'b1, R_TX_PDA + 1, 32'(pda[47:32]));
        for (int c = 0; c < NCLS; c++) begin
            txq[c] = 16'($urandom());
            apb(1'b1, R_TX_QT + c, {16'h0, txq[c]});
        end
        for (int r = 0; r < 2; r++) begin
            for (int c = NCLS - 1; c >= 0; c--) begin
                cls_q.push_back(c);
            end
            dly <= 4'($urandom_range(6, 0));
            @(posedge ref_clk);
            tx_req <= 9'h1FF;
            tx_resend <= (r == 1);
            @(posedge ref_clk);
            tx_resend <= 1'b0;
            wait_q();
        end
        tx_req <= 9'h000;
        apb(1'b1, R_TX_EN, 32'h0000_01F7);
        tx_req <= 9'h008;
        repeat (30) @(posedge ref_clk);
        apb(1'b1, R_TX_QT + GLB, {16'h0010, txq[GLB]});
        cls_q.push_back(GLB);
        cls_q.push_back(GLB);
        tx_req <= 9'h108;
        wait_q();
        tx_req <= 9'h000;
        $display("test transmit done");
        apb(1'b1, R_RX_CHK, 32'h2121_2121);
        apb(1'b1, R_RX_PCP_OP, 32'h0300_0300);
        apb(1'b1, R_RX_GCP_OP, 32'h02FF_0200);
        apb(1'b1, R_RX_GPP, {GOP, 16'h0});
        apb(1'b1, R_RX_PPP, {POP, 16'h0});
        apb(1'b1, R_RX_CTL, 32'h0000_07FF);
        rx_send(GOP, 8'h00, 9'h1FF, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk(rx_req[GLB], 1'b1);
        apb(1'b0, R_STATUS, 32'h0);
        chk(rd, 32'h0000_0100);
        rx_ack <= 9'h100;
        @(posedge ref_clk);
        rx_ack <= 9'h000;
        chk(rx_req[GLB], 1'b1);
        @(posedge ref_clk);
        chk(rx_req[GLB], 1'b0);
        apb(1'b1, R_RX_CTL, 32'h0000_05FF);
        rx_send(POP, 8'hA5, 9'h1FF, 1'b1);
        @(posedge ref_clk);
        chk(rx_req, 9'h000);
        apb(1'b1, R_RX_CTL, 32'h0000_00FF);
        rx_send(GOP, 8'h00, 9'h0FF, 1'b0);
        rx_send(16'h02FF, 8'h00, 9'h0FF, 1'b0);
        rx_send(16'h0300, 8'h00, 9'h0FF, 1'b0);
        apb(1'b1, R_RX_CTL, 32'h0000_05FF);
        apb(1'b1, R_RX_UDA, pda[31:0]);
        apb(1'b1, R_RX_UDA + 1, 32'(pda[47:32]));
        apb(1'b1, R_RX_CHK, 32'h0028_0000);
        rx_hdr.hdr.da <= pda;
        rx_send(GOP, 8'h00, 9'h1FF, 1'b1);
        rx_hdr.hdr.da <= ~pda;
        rx_send(16'h0400, 8'h00, 9'h1FF, 1'b1);
        $display("test receive done");
        finish_test();
    end
endmodule // tb_pfc_top
